// [logic/pfcp_defines.vh]
// timing counts and threshold codes for the pfc protection fault logic
`ifndef PFCP_DEFINES_VH
`define PFCP_DEFINES_VH
`define PFCP_CLK_PERIOD_NS 25
`define PFCP_PHASE_IDLE_US 400
// 400 us of 25 ns cycles, sized to the idle counter so nothing is cut silently
`define PFCP_PHASE_IDLE_CYC 14'h3e80
`define PFCP_IDLE_W 14
`define PFCP_OC_TWO_PHASE 2'h1
`define PFCP_OC_ONE_PHASE 2'h2
`define PFCP_SYNC_W 12
`endif

// [logic/pfcp_fault_logic.v]
// protection fault logic for a two-phase interleaved pfc controller
// What this block does
// - reference off in lockout or sense disabled
// - low overvoltage pulls comp down, hysteresis release
// - high overvoltage also stops gate switching
// - sense overvoltage never forces soft-start
// - redundant overvoltage stops switching, pulls comp
// - redundant release needs clear and comp discharged
// - re-enable only when both senses normal
// - overcurrent threshold two-phase or single-phase select
// - overcurrent kills both gates, no soft-start
// - overcurrent clears above clear level
// - after overcurrent both switches restart together
// - sense below disable level: full shutdown, soft-start
// - re-enable above enable level under soft-start
// - supply lockout stops gates, restart soft-start
// - idle zero-crossing selects single-phase threshold
// - phase monitor off single-phase or comp low
// - comp below second-channel threshold: single phase in run
// - soft-start faults latch until comp discharged
`timescale 1ns/1ps
`include "pfcp_defines.vh"
module pfcp_fault_logic (
  input wire mclk,
  input wire rst,
  input wire ce,
  // comparator results, asynchronous to mclk
  input wire supplyLockout,
  input wire senseAboveEnable,
  input wire senseBelowDisable,
  input wire senseAboveLowOv,
  input wire senseBelowLowOvHyst,
  input wire senseAboveHighOv,
  input wire redundantAboveFault,
  input wire redundantBelowClear,
  input wire compBelowDischarged,
  input wire compBelowMonitorLevel,
  input wire compBelowSecondChannel,
  input wire overcurrentTrip,
  input wire currentAboveClear,
  input wire zeroCrossA,
  input wire zeroCrossB,
  input wire externalSoftStartFault,
  input wire softStartDone,
  // controls to the analog and pwm sections
  output reg referenceEnable,
  output reg compPullDown,
  output reg gateEnableA,
  output reg gateEnableB,
  output reg biasEnable,
  output reg softStartActive,
  output reg [1:0] overcurrentSelect,
  output reg doubleOnTimeA,
  output reg phaseFailure,
  output reg simultaneousRestart
);
  // state machine codes, one-hot
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_DISCHARGE = 4'h2;
  localparam [3:0] ST_SOFTSTART = 4'h4;
  localparam [3:0] ST_RUN = 4'h8;

  wire [`PFCP_SYNC_W-1:0] rawIn;
  wire [`PFCP_SYNC_W-1:0] syncIn;
  wire uvloS, enS, disS, lowOvS, lowHystS, highOvS;
  wire hvFltS, hvClrS, compDisS, compMonS, compPhbS, ocS;
  reg ocClrS1, ocClrS2, extS1, extS2, ssDoneS1, ssDoneS2;
  reg zcA1, zcA2, zcB1, zcB2;

  reg [3:0] state;
  reg [3:0] next_state;
  reg senseEnabled;
  reg lowOvLatch;
  reg highOvLatch;
  reg hvLatch;
  reg ocLatch;
  reg ssFaultLatch;
  reg phaseFailLatch;
  wire idleA, idleB;
  wire monitorEnable;
  wire singlePhase;
  wire ssFaultNow;
  wire switchInhibit;
  wire switchState;

  // comparator results pass two flops before any logic sees them
  assign rawIn = {supplyLockout, senseAboveEnable, senseBelowDisable, senseAboveLowOv,
                  senseBelowLowOvHyst, senseAboveHighOv, redundantAboveFault, redundantBelowClear,
                  compBelowDischarged, compBelowMonitorLevel, compBelowSecondChannel, overcurrentTrip};
  pfcp_sync #(.W(`PFCP_SYNC_W)) uSync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );
  assign {uvloS, enS, disS, lowOvS, lowHystS, highOvS, hvFltS, hvClrS, compDisS, compMonS, compPhbS, ocS} = syncIn;

  // remaining async inputs, kept separate because the zero-crossing
  // edges must not be delayed differently between phases
  always @(posedge mclk) begin
    if (rst) begin
      ocClrS1 <= 1'b0;
      ocClrS2 <= 1'b0;
      extS1 <= 1'b0;
      extS2 <= 1'b0;
      ssDoneS1 <= 1'b0;
      ssDoneS2 <= 1'b0;
      zcA1 <= 1'b0;
      zcA2 <= 1'b0;
      zcB1 <= 1'b0;
      zcB2 <= 1'b0;
    end else if (ce) begin
      ocClrS1 <= currentAboveClear;
      ocClrS2 <= ocClrS1;
      extS1 <= externalSoftStartFault;
      extS2 <= extS1;
      ssDoneS1 <= softStartDone;
      ssDoneS2 <= ssDoneS1;
      zcA1 <= zeroCrossA;
      zcA2 <= zcA1;
      zcB1 <= zeroCrossB;
      zcB2 <= zcB1;
    end
  end

  // enable hysteresis: off below 1.20 V, on above 1.25 V
  always @(posedge mclk) begin
    if (rst) begin
      senseEnabled <= 1'b0;
    end else if (ce) begin
      if (disS) begin
        senseEnabled <= 1'b0;
      end else if (enS) begin
        senseEnabled <= 1'b1;
      end
    end
  end

  // sense overvoltage latches with 2% hysteresis, no soft-start link
  always @(posedge mclk) begin
    if (rst) begin
      lowOvLatch <= 1'b0;
      highOvLatch <= 1'b0;
    end else if (ce) begin
      if (lowOvS) begin
        lowOvLatch <= 1'b1;
      end else if (lowHystS) begin
        lowOvLatch <= 1'b0;
      end
      if (highOvS) begin
        highOvLatch <= 1'b1;
      end else if (lowHystS) begin
        highOvLatch <= 1'b0;
      end
    end
  end

  // redundant overvoltage holds until below clear and comp discharged
  always @(posedge mclk) begin
    if (rst) begin
      hvLatch <= 1'b0;
    end else if (ce) begin
      if (hvFltS) begin
        hvLatch <= 1'b1;
      end else if (hvClrS && compDisS) begin
        hvLatch <= 1'b0;
      end
    end
  end

  // overcurrent: set wins over clear in the same cycle
  always @(posedge mclk) begin
    if (rst) begin
      ocLatch <= 1'b0;
      simultaneousRestart <= 1'b0;
    end else if (ce) begin
      if (ocS) begin
        ocLatch <= 1'b1;
      end else if (ocClrS2) begin
        ocLatch <= 1'b0;
      end
      // one-cycle pulse telling the pwm to fire both phases in step
      simultaneousRestart <= ocLatch & ~ocS & ocClrS2;
    end
  end

  // every soft-start fault, however brief
  assign ssFaultNow = uvloS | ~senseEnabled | hvFltS | hvLatch | extS2;

  // latch is released only once comp is discharged and faults gone
  always @(posedge mclk) begin
    if (rst) begin
      ssFaultLatch <= 1'b1;
    end else if (ce) begin
      if (ssFaultNow) begin
        ssFaultLatch <= 1'b1;
      end else if (compDisS) begin
        ssFaultLatch <= 1'b0;
      end
    end
  end

  // phase monitor runs only in two-phase with comp above 250 mV
  assign monitorEnable = (state == ST_RUN) & ~compPhbS & ~compMonS;
  pfcp_idle_timer uIdleA (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .enable(monitorEnable),
    .pulse(zcA2),
    .expired(idleA)
  );
  // phase b timer mirrors phase a so the two idle spans compare fairly
  pfcp_idle_timer uIdleB (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .enable(monitorEnable),
    .pulse(zcB2),
    .expired(idleB)
  );

  // failure is one phase idle while the other keeps switching
  always @(posedge mclk) begin
    if (rst) begin
      phaseFailLatch <= 1'b0;
    end else if (ce) begin
      if (ssFaultLatch) begin
        phaseFailLatch <= 1'b0;
      end else if (monitorEnable && (idleA ^ idleB)) begin
        phaseFailLatch <= 1'b1;
      end
    end
  end

  // either a failed phase or a low comp level means one phase carries the load
  assign singlePhase = phaseFailLatch | compPhbS;

  // sequencing between off, discharge, soft-start and run
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (!uvloS) begin
          next_state = ST_DISCHARGE;
        end
      end
      ST_DISCHARGE: begin
        if (uvloS) begin
          next_state = ST_OFF;
        end else if (!ssFaultLatch && !ssFaultNow) begin
          next_state = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART: begin
        if (uvloS) begin
          next_state = ST_OFF;
        end else if (ssFaultNow) begin
          next_state = ST_DISCHARGE;
        end else if (ssDoneS2) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // sense overvoltage and overcurrent stay here
        if (uvloS) begin
          next_state = ST_OFF;
        end else if (ssFaultNow) begin
          next_state = ST_DISCHARGE;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // state advances only while the clock enable is high
  always @(posedge mclk) begin
    if (rst) begin
      state <= ST_OFF;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // switching stops on either overvoltage latch or any overcurrent; the raw
  // synchronised trip is included so the gates drop on the same edge that sets the latch
  assign switchInhibit = highOvLatch | hvLatch | ocLatch | ocS;
  // gates may run only in soft-start or run
  assign switchState = (next_state == ST_SOFTSTART) | (next_state == ST_RUN);

  // reference and bias follow lockout and the enable hysteresis only
  always @(posedge mclk) begin
    if (rst) begin
      referenceEnable <= 1'b0;
      biasEnable <= 1'b0;
    end else if (ce) begin
      referenceEnable <= ~uvloS & senseEnabled;
      biasEnable <= ~uvloS & senseEnabled;
    end
  end

  // comp is pulled down in lockout, discharge, or either overvoltage;
  // overcurrent leaves it alone so the error amplifier is undisturbed
  always @(posedge mclk) begin
    if (rst) begin
      compPullDown <= 1'b1;
    end else if (ce) begin
      compPullDown <= (next_state == ST_OFF) | (next_state == ST_DISCHARGE)
                      | lowOvLatch | hvLatch;
    end
  end

  // gate drives; during soft-start both phases run regardless of comp level
  always @(posedge mclk) begin
    if (rst) begin
      gateEnableA <= 1'b0;
      gateEnableB <= 1'b0;
    end else if (ce) begin
      gateEnableA <= switchState & ~switchInhibit;
      gateEnableB <= ((next_state == ST_SOFTSTART) | ((next_state == ST_RUN) & ~compPhbS))
                     & ~switchInhibit;
    end
  end

  // mode outputs: soft-start flag, overcurrent threshold, on-time doubling
  always @(posedge mclk) begin
    if (rst) begin
      softStartActive <= 1'b0;
      overcurrentSelect <= `PFCP_OC_TWO_PHASE;
      doubleOnTimeA <= 1'b0;
      phaseFailure <= 1'b0;
    end else if (ce) begin
      softStartActive <= (next_state == ST_SOFTSTART) | (next_state == ST_DISCHARGE);
      overcurrentSelect <= singlePhase ? `PFCP_OC_ONE_PHASE : `PFCP_OC_TWO_PHASE;
      doubleOnTimeA <= (next_state == ST_RUN) & compPhbS;
      phaseFailure <= phaseFailLatch;
    end
  end
endmodule

// [logic/pfcp_idle_timer.v]
// zero-crossing idle counter, restarts on each pulse
`timescale 1ns/1ps
`include "pfcp_defines.vh"
module pfcp_idle_timer #(
  parameter [`PFCP_IDLE_W-1:0] IDLE_CYC = `PFCP_PHASE_IDLE_CYC
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire enable,
  input wire pulse,
  output reg expired
);
  reg [`PFCP_IDLE_W-1:0] count;
  reg pulseDly;
  wire pulseRise;
  assign pulseRise = pulse & ~pulseDly;
  // counts cycles since the last rising edge; saturates at the limit
  always @(posedge mclk) begin
    if (rst) begin
      count <= {`PFCP_IDLE_W{1'b0}};
      pulseDly <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      pulseDly <= pulse;
      if (!enable || pulseRise) begin
        count <= {`PFCP_IDLE_W{1'b0}};
        expired <= 1'b0;
      end else if (count >= IDLE_CYC - 1'b1) begin
        expired <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

// [logic/pfcp_sync.v]
// two-stage synchroniser bank for comparator results
`timescale 1ns/1ps
module pfcp_sync #(
  parameter W = 12
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gs
      reg stage1;
      reg stage2;
      // first stage feeds only the second stage
      always @(posedge mclk) begin
        if (rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else if (ce) begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
        end
      end
      assign syncOut[i] = stage2;
    end
  endgenerate
endmodule

// [verif/pfcp_fault_logic_sva.sv]
// port-level assertions for the pfc protection fault logic
`timescale 1ns/1ps
`include "pfcp_defines.vh"
module pfcp_fault_logic_sva (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire supplyLockout,
  input wire senseBelowDisable,
  input wire senseAboveLowOv,
  input wire senseAboveHighOv,
  input wire redundantAboveFault,
  input wire compBelowSecondChannel,
  input wire overcurrentTrip,
  input wire referenceEnable,
  input wire compPullDown,
  input wire gateEnableA,
  input wire gateEnableB,
  input wire biasEnable,
  input wire [1:0] overcurrentSelect,
  input wire doubleOnTimeA,
  input wire simultaneousRestart
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);
  // a level held four edges has crossed both sync flops and the output register
  AST_REF_OFF: assert property (supplyLockout[*4] |=> !referenceEnable)
    else $error("ref on in lockout");
  AST_LOW_OV: assert property (senseAboveLowOv[*4] |=> compPullDown)
    else $error("no pull-down on ov");
  AST_HIGH_OV: assert property (senseAboveHighOv[*4] |=> !gateEnableA && !gateEnableB)
    else $error("gates on ov");
  AST_REDUNDANT: assert property (redundantAboveFault[*4] |=> compPullDown && !gateEnableA && !gateEnableB)
    else $error("redundant ov ignored");
  AST_ONE_PHASE: assert property (compBelowSecondChannel[*4] |=>
    overcurrentSelect == `PFCP_OC_ONE_PHASE && doubleOnTimeA) else $error("single phase not selected");
  AST_OC_OFF: assert property (overcurrentTrip[*4] |=> !gateEnableA && !gateEnableB)
    else $error("gates on oc");
  AST_DISABLED: assert property (senseBelowDisable[*4] |=> !biasEnable && compPullDown && !gateEnableA)
    else $error("not disabled");
  AST_LOCKOUT: assert property (supplyLockout[*4] |=> compPullDown && !gateEnableA && !gateEnableB)
    else $error("lockout ignored");
  AST_RESTART: assert property (simultaneousRestart |=>
    !simultaneousRestart ##[0:1] (gateEnableA && gateEnableB)) else $error("restart not joint");
endmodule
bind pfcp_fault_logic pfcp_fault_logic_sva u_pfcp_fault_logic_sva (.mclk(mclk), .rst(rst), .ce(ce),
  .supplyLockout(supplyLockout), .senseBelowDisable(senseBelowDisable), .senseAboveLowOv(senseAboveLowOv),
  .senseAboveHighOv(senseAboveHighOv), .redundantAboveFault(redundantAboveFault),
  .compBelowSecondChannel(compBelowSecondChannel), .overcurrentTrip(overcurrentTrip),
  .referenceEnable(referenceEnable), .compPullDown(compPullDown), .gateEnableA(gateEnableA),
  .gateEnableB(gateEnableB), .biasEnable(biasEnable), .overcurrentSelect(overcurrentSelect),
  .doubleOnTimeA(doubleOnTimeA), .simultaneousRestart(simultaneousRestart));

// [verif/pfcp_stage_model.sv]
// boost stage stand-in: zero-crossing pulses and compensation node level
`timescale 1ns/1ps
module pfcp_stage_model #(
  parameter CHARGE_CYC = 40,
  parameter ZCD_CYC = 10
) (
  input wire mclk,
  input wire gateEnableA,
  input wire gateEnableB,
  input wire compPullDown,
  input wire stallB,
  output reg zeroCrossA = 1'b0,
  output reg zeroCrossB = 1'b0,
  output reg compBelowDischarged = 1'b1,
  output reg compBelowMonitorLevel = 1'b1
);
  integer compLevel = 0;
  integer zcdCount = 0;
  // the node ramps one step a cycle, so a release never shows an instant discharge
  always @(negedge mclk) begin
    if (compPullDown && compLevel > 0)
      compLevel = compLevel - 1;
    else if (!compPullDown && compLevel < CHARGE_CYC)
      compLevel = compLevel + 1;
    zcdCount = (zcdCount + 1) % ZCD_CYC;
    zeroCrossA <= gateEnableA && zcdCount == 0;
    zeroCrossB <= gateEnableB && !stallB && zcdCount == ZCD_CYC / 2; // stall mimics a dead phase
    compBelowDischarged <= compLevel == 0;
    compBelowMonitorLevel <= compLevel < CHARGE_CYC / 4;
  end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the pfc protection fault logic
`timescale 1ns/1ps
`include "pfcp_defines.vh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  reg mclk, rst = 1'b1, ce = 1'b1, supplyLockout = 1'b1, senseAboveEnable = 1'b0, senseBelowDisable = 1'b1;
  reg senseAboveLowOv = 1'b0, senseBelowLowOvHyst = 1'b1, senseAboveHighOv = 1'b0, redundantAboveFault = 1'b0;
  reg redundantBelowClear = 1'b1, compBelowSecondChannel = 1'b0, overcurrentTrip = 1'b0, currentAboveClear = 1'b1;
  reg externalSoftStartFault = 1'b0, softStartDone = 1'b0, stallB = 1'b0;
  wire referenceEnable, compPullDown, gateEnableA, gateEnableB, biasEnable, softStartActive, doubleOnTimeA;
  wire phaseFailure, simultaneousRestart, zeroCrossA, zeroCrossB, compBelowDischarged, compBelowMonitorLevel;
  wire [1:0] overcurrentSelect;
  integer failures = 0, totalChecks = 0, n;
  pfcp_fault_logic u_pfcp_fault_logic (.mclk(mclk), .rst(rst), .ce(ce), .supplyLockout(supplyLockout),
    .senseAboveEnable(senseAboveEnable), .senseBelowDisable(senseBelowDisable), .senseAboveLowOv(senseAboveLowOv),
    .senseBelowLowOvHyst(senseBelowLowOvHyst), .senseAboveHighOv(senseAboveHighOv),
    .redundantAboveFault(redundantAboveFault), .redundantBelowClear(redundantBelowClear),
    .compBelowDischarged(compBelowDischarged), .compBelowMonitorLevel(compBelowMonitorLevel),
    .compBelowSecondChannel(compBelowSecondChannel), .overcurrentTrip(overcurrentTrip),
    .currentAboveClear(currentAboveClear), .zeroCrossA(zeroCrossA), .zeroCrossB(zeroCrossB),
    .externalSoftStartFault(externalSoftStartFault), .softStartDone(softStartDone),
    .referenceEnable(referenceEnable), .compPullDown(compPullDown), .gateEnableA(gateEnableA),
    .gateEnableB(gateEnableB), .biasEnable(biasEnable), .softStartActive(softStartActive),
    .overcurrentSelect(overcurrentSelect), .doubleOnTimeA(doubleOnTimeA), .phaseFailure(phaseFailure),
    .simultaneousRestart(simultaneousRestart));
  pfcp_stage_model u_pfcp_stage_model (.mclk(mclk), .gateEnableA(gateEnableA), .gateEnableB(gateEnableB),
    .compPullDown(compPullDown), .stallB(stallB), .zeroCrossA(zeroCrossA), .zeroCrossB(zeroCrossB),
    .compBelowDischarged(compBelowDischarged), .compBelowMonitorLevel(compBelowMonitorLevel));
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // inputs move on falling edges, away from the sampling edge
  task wt(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // the run needs about 17k cycles, so 40k cycles means a hang
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
  initial begin
    wt(4);
    `CHK({referenceEnable, compPullDown, gateEnableA, gateEnableB, biasEnable, softStartActive}, 6'h10)
    `CHK(overcurrentSelect, `PFCP_OC_TWO_PHASE)
    wt(1);
    rst = 1'b0;
    supplyLockout = 1'b0;
    senseAboveEnable = 1'b1;
    senseBelowDisable = 1'b0;
    wt(12);
    `CHK({referenceEnable, softStartActive, gateEnableA, gateEnableB}, 4'hf)
    softStartDone = 1'b1;
    wt(60);
    senseAboveLowOv = 1'b1;
    senseBelowLowOvHyst = 1'b0;
    wt(8);
    `CHK({compPullDown, softStartActive, gateEnableA, gateEnableB}, 4'hb)
    senseAboveLowOv = 1'b0;
    wt(8);
    `CHK(compPullDown, 1'b1)
    senseBelowLowOvHyst = 1'b1;
    wt(8);
    `CHK(compPullDown, 1'b0)
    {senseAboveLowOv, senseAboveHighOv, senseBelowLowOvHyst} = 3'h6;
    wt(8);
    `CHK({gateEnableA, gateEnableB}, 2'h0)
    {senseAboveLowOv, senseAboveHighOv} = 2'h0;
    wt(8);
    `CHK({gateEnableA, gateEnableB}, 2'h0)
    senseBelowLowOvHyst = 1'b1;
    wt(8);
    `CHK({softStartActive, gateEnableA, gateEnableB}, 3'h3)
    {overcurrentTrip, currentAboveClear} = 2'h2;
    wt(8);
    `CHK({compPullDown, softStartActive, gateEnableA, gateEnableB}, 4'h0)
    {overcurrentTrip, currentAboveClear} = 2'h1;
    n = 0;
    while (simultaneousRestart !== 1'b1 && n < 40) begin
      wt(1);
      n++;
    end
    `CHK(simultaneousRestart, 1'b1)
    wt(2);
    `CHK({gateEnableA, gateEnableB}, 2'h3)
    compBelowSecondChannel = 1'b1;
    wt(8);
    `CHK({overcurrentSelect, doubleOnTimeA, gateEnableB}, {`PFCP_OC_ONE_PHASE, 2'h2})
    compBelowSecondChannel = 1'b0;
    wt(40);
    `CHK({overcurrentSelect, doubleOnTimeA}, {`PFCP_OC_TWO_PHASE, 1'b0})
    stallB = 1'b1;
    wt(16100);
    `CHK({phaseFailure, overcurrentSelect}, {1'b1, `PFCP_OC_ONE_PHASE})
    stallB = 1'b0;
    {softStartDone, senseBelowDisable, senseAboveEnable} = 3'h2;
    wt(8);
    `CHK({referenceEnable, compPullDown, gateEnableA, gateEnableB, biasEnable}, 5'h08)
    {senseBelowDisable, senseAboveEnable} = 2'h1;
    wt(60);
    `CHK({phaseFailure, softStartActive, gateEnableA, gateEnableB}, 4'h7)
    softStartDone = 1'b1;
    wt(60);
    {softStartDone, redundantAboveFault, redundantBelowClear} = 3'h2;
    wt(8);
    `CHK({compPullDown, gateEnableA, gateEnableB}, 3'h4)
    {redundantAboveFault, redundantBelowClear} = 2'h1;
    wt(6);
    `CHK({compPullDown, gateEnableA, gateEnableB}, 3'h4)
    wt(50);
    `CHK({compPullDown, softStartActive, gateEnableA, gateEnableB}, 4'h7)
    softStartDone = 1'b1;
    wt(60);
    softStartDone = 1'b0;
    externalSoftStartFault = 1'b1;
    wt(1);
    externalSoftStartFault = 1'b0;
    wt(12);
    `CHK({compPullDown, gateEnableA, gateEnableB}, 3'h4)
    wt(50);
    `CHK({softStartActive, gateEnableA, gateEnableB}, 3'h7)
    // with the enable low nothing may move, not even on a lockout
    ce = 1'b0;
    supplyLockout = 1'b1;
    wt(8);
    `CHK({referenceEnable, softStartActive, gateEnableA, gateEnableB}, 4'hf)
    ce = 1'b1;
    wt(8);
    `CHK({referenceEnable, compPullDown, gateEnableA, gateEnableB}, 4'h4)
    supplyLockout = 1'b0;
    wt(60);
    `CHK({referenceEnable, softStartActive, gateEnableA, gateEnableB}, 4'hf)
    report_and_stop();
  end
endmodule
